// file: hdl/twc_controller.v
// Two-wire bus controller: slave, single master and multi-master
`timescale 1ns/10ps
`include "twc_defines.vh"
module twc_controller #(
    parameter [`TWC_DIV_W-1:0] QUARTER_DIV = `TWC_DIV_DEFAULT
) (
    input  wire                   SYS_CLK,
    input  wire                   RESET,
    input  wire                   SCL_I,
    output wire                   SCL_O,
    output wire                   SCL_OE_N,
    input  wire                   SDA_I,
    output wire                   SDA_O,
    output wire                   SDA_OE_N,
    input  wire                   CLK_EN,
    input  wire                   SLAVE_EN,
    input  wire                   MASTER_EN,
    input  wire                   HW_MATCH_ENABLE,
    input  wire                   BLOCK_ON,
    input  wire                   SLEEP_REFUSE_ALL,
    input  wire                   POWER_DOWN,
    input  wire [`TWC_ADDR_W-1:0] OWN_ADDR,
    input  wire                   START_REQ,
    input  wire                   RESTART_REQ,
    input  wire                   STOP_REQ,
    input  wire [7:0]             TX_DATA,
    input  wire                   TX_LOAD,
    input  wire                   ACK_CMD,
    input  wire                   NACK_CMD,
    input  wire                   TRANSMIT_CMD,
    input  wire                   RECEIVE_CMD,
    input  wire                   CSR_CLEAR,
    input  wire                   INT_BYTE_EN,
    input  wire                   INT_ERR_EN,
    input  wire                   INT_STOP_EN,
    output reg  [7:0]             RX_DATA,
    output reg                    BYTE_COMPLETE,
    output reg                    LAST_ACKED,
    output reg                    ADDRESSED,
    output reg                    LOST_ARB,
    output reg                    STOP_SEEN,
    output reg                    BUS_ERROR,
    output reg                    START_PENDING,
    output reg                    BUS_BUSY,
    output wire                   BUS_FREE,
    output reg                    MASTER_ACTIVE,
    output wire                   SLEEP_READY_FLAG,
    output reg                    WAKEUP,
    output wire                   IRQ
);
    wire scl;
    wire scl_rise;
    wire scl_fall;
    wire sda;
    wire sda_rise;
    wire sda_fall;

    twc_edge_sync u_scl (
        .clk   (SYS_CLK),
        .rst   (RESET),
        .din   (SCL_I),
        .level (scl),
        .rise  (scl_rise),
        .fall  (scl_fall)
    );
    twc_edge_sync u_sda (
        .clk   (SYS_CLK),
        .rst   (RESET),
        .din   (SDA_I),
        .level (sda),
        .rise  (sda_rise),
        .fall  (sda_fall)
    );

    wire start_det = sda_fall & scl;
    wire stop_det  = sda_rise & scl;

    reg  [`TWC_DIV_W-1:0] div_q;
    reg  [1:0]            phase_q;
    reg  [3:0]            st_q;
    reg  [`TWC_BIT_W-1:0] bit_q;
    reg  [7:0]            sh_q;
    reg  [7:0]            tx_q;
    reg                   scl_drv_q;
    reg                   sda_drv_q;
    reg                   is_addr_q;
    reg                   rx_dir_q;
    reg                   ack_out_q;
    reg                   held_q;

    wire tick = (div_q == {`TWC_DIV_W{1'b0}});
    // Slave listens unless master-only; a stall hold is released by firmware
    wire slave_on = SLAVE_EN & CLK_EN;
    // During power-down only the hardware matcher may answer
    wire sleep_ok = SLAVE_EN & HW_MATCH_ENABLE & BLOCK_ON
                    & (OWN_ADDR != {`TWC_ADDR_W{1'b0}});
    wire addr_hit = (sh_q[7:1] == OWN_ADDR);

    assign BUS_FREE         = ~BUS_BUSY;
    assign SLEEP_READY_FLAG = SLEEP_REFUSE_ALL & (st_q == `TWC_ST_IDLE) & ~BUS_BUSY;
    assign SCL_O            = 1'b0;
    assign SDA_O            = 1'b0;
    assign SCL_OE_N         = ~(scl_drv_q | held_q);
    assign SDA_OE_N         = ~sda_drv_q;
    assign IRQ = (INT_BYTE_EN & BYTE_COMPLETE)
               | (INT_ERR_EN & (BUS_ERROR | LOST_ARB))
               | (INT_STOP_EN & STOP_SEEN) | WAKEUP;

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            div_q <= {`TWC_DIV_W{1'b0}};
            phase_q <= 2'h0;
        end else if (tick) begin
            div_q <= QUARTER_DIV;
            phase_q <= phase_q + 2'h1;
        end else begin
            div_q <= div_q - {{(`TWC_DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            st_q <= `TWC_ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            is_addr_q <= 1'b0;
            rx_dir_q <= 1'b1;
            ack_out_q <= 1'b0;
            held_q <= 1'b0;
            RX_DATA <= 8'h00;
            BYTE_COMPLETE <= 1'b0;
            LAST_ACKED <= 1'b0;
            ADDRESSED <= 1'b0;
            LOST_ARB <= 1'b0;
            STOP_SEEN <= 1'b0;
            BUS_ERROR <= 1'b0;
            START_PENDING <= 1'b0;
            BUS_BUSY <= 1'b0;
            MASTER_ACTIVE <= 1'b0;
            WAKEUP <= 1'b0;
        end else begin
            if (TX_LOAD)
                tx_q <= TX_DATA;
            if (START_REQ | RESTART_REQ)
                START_PENDING <= 1'b1;
            if (CSR_CLEAR) begin
                BYTE_COMPLETE <= 1'b0;
                LOST_ARB <= 1'b0;
                STOP_SEEN <= 1'b0;
                BUS_ERROR <= 1'b0;
                ADDRESSED <= 1'b0;
                WAKEUP <= 1'b0;
            end
            if (start_det)
                BUS_BUSY <= 1'b1;
            if (stop_det) begin
                BUS_BUSY <= 1'b0;
                STOP_SEEN <= 1'b1;
            end
            case (st_q)
            `TWC_ST_IDLE: begin
                scl_drv_q <= 1'b0;
                sda_drv_q <= 1'b0;
                if (start_det & (slave_on | (POWER_DOWN & sleep_ok))) begin
                    st_q <= `TWC_ST_SHIFT;
                    bit_q <= 4'h0;
                    is_addr_q <= 1'b1;
                    rx_dir_q <= 1'b1;
                    MASTER_ACTIVE <= 1'b0;
                end else if (START_PENDING & MASTER_EN & CLK_EN & ~BUS_BUSY
                             & ~start_det) begin
                    st_q <= `TWC_ST_START;
                    sda_drv_q <= 1'b1;
                    MASTER_ACTIVE <= 1'b1;
                end else if (START_PENDING & BUS_BUSY & SLAVE_EN & ~MASTER_ACTIVE
                             & ~ADDRESSED) begin
                    // Start request stays set so firmware sees it was not issued
                    ADDRESSED <= 1'b1;
                    BYTE_COMPLETE <= 1'b1;
                end
            end
            `TWC_ST_START: if (tick & phase_q == 2'h3) begin
                START_PENDING <= 1'b0;
                scl_drv_q <= 1'b1;
                sh_q <= tx_q;
                is_addr_q <= 1'b1;
                rx_dir_q <= 1'b0;
                bit_q <= 4'h0;
                st_q <= `TWC_ST_SHIFT;
            end
            `TWC_ST_SHIFT: begin
                if (MASTER_ACTIVE) begin
                    if (tick & phase_q == 2'h0) begin
                        scl_drv_q <= 1'b1;
                        sda_drv_q <= ~rx_dir_q & ~sh_q[7];
                    end
                    if (tick & phase_q == 2'h1)
                        scl_drv_q <= 1'b0;
                    if (tick & phase_q == 2'h2 & scl) begin
                        if (~rx_dir_q & sh_q[7] & ~sda) begin
                            LOST_ARB <= 1'b1;
                            BYTE_COMPLETE <= 1'b1;
                            scl_drv_q <= 1'b0;
                            sda_drv_q <= 1'b0;
                            MASTER_ACTIVE <= 1'b0;
                            if (SLAVE_EN) begin
                                ADDRESSED <= is_addr_q;
                                st_q <= `TWC_ST_SKIP;
                            end else begin
                                st_q <= `TWC_ST_LOST;
                            end
                        end else begin
                            sh_q <= {sh_q[6:0], sda};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    if (tick & phase_q == 2'h3 & bit_q == `TWC_BYTE_BITS) begin
                        scl_drv_q <= 1'b1;
                        sda_drv_q <= rx_dir_q & ack_out_q;
                        st_q <= `TWC_ST_ACK;
                    end
                end else if (scl_rise) begin
                    sh_q <= {sh_q[6:0], sda};
                    bit_q <= bit_q + 4'h1;
                end else if (scl_fall & bit_q == `TWC_BYTE_BITS) begin
                    if (is_addr_q & (HW_MATCH_ENABLE | POWER_DOWN)) begin
                        if (addr_hit & ~(SLEEP_REFUSE_ALL & ~POWER_DOWN)) begin
                            RX_DATA <= sh_q;
                            ADDRESSED <= 1'b1;
                            BYTE_COMPLETE <= 1'b1;
                            WAKEUP <= POWER_DOWN;
                            sda_drv_q <= 1'b1;
                            st_q <= `TWC_ST_ACK;
                        end else begin
                            st_q <= `TWC_ST_SKIP;
                        end
                    end else begin
                        RX_DATA <= sh_q;
                        BYTE_COMPLETE <= 1'b1;
                        ADDRESSED <= is_addr_q;
                        held_q <= 1'b1;
                        st_q <= `TWC_ST_HOLD;
                    end
                end
            end
            `TWC_ST_ACK: begin
                if (MASTER_ACTIVE) begin
                    if (tick & phase_q == 2'h0)
                        scl_drv_q <= 1'b1;
                    if (tick & phase_q == 2'h1)
                        scl_drv_q <= 1'b0;
                    if (tick & phase_q == 2'h2) begin
                        LAST_ACKED <= ~sda;
                        if (rx_dir_q)
                            RX_DATA <= sh_q;
                        else
                            rx_dir_q <= is_addr_q & tx_q[0];
                    end
                    if (tick & phase_q == 2'h3) begin
                        scl_drv_q <= 1'b1;
                        sda_drv_q <= 1'b0;
                        BYTE_COMPLETE <= 1'b1;
                        held_q <= 1'b1;
                        st_q <= `TWC_ST_HOLD;
                    end
                end else if (scl_fall) begin
                    sda_drv_q <= 1'b0;
                    held_q <= 1'b1;
                    st_q <= `TWC_ST_HOLD;
                end
            end
            `TWC_ST_HOLD: begin
                scl_drv_q <= 1'b0;
                if (MASTER_ACTIVE & STOP_REQ) begin
                    held_q <= 1'b0;
                    scl_drv_q <= 1'b1;
                    sda_drv_q <= 1'b1;
                    st_q <= `TWC_ST_STOP;
                end else if (MASTER_ACTIVE & (RESTART_REQ | START_REQ)) begin
                    held_q <= 1'b0;
                    scl_drv_q <= 1'b1;
                    sda_drv_q <= 1'b0;
                    st_q <= `TWC_ST_IDLE;
                    BUS_BUSY <= 1'b0;
                end else if (TRANSMIT_CMD | RECEIVE_CMD | ACK_CMD | NACK_CMD) begin
                    held_q <= 1'b0;
                    is_addr_q <= 1'b0;
                    bit_q <= 4'h0;
                    ack_out_q <= ACK_CMD;
                    if (TRANSMIT_CMD | RECEIVE_CMD)
                        rx_dir_q <= RECEIVE_CMD;
                    sh_q <= tx_q;
                    st_q <= (~MASTER_ACTIVE & NACK_CMD) ? `TWC_ST_SKIP : `TWC_ST_SHIFT;
                end
            end
            `TWC_ST_STOP: if (tick & phase_q == 2'h1) begin
                scl_drv_q <= 1'b0;
            end else if (tick & phase_q == 2'h3) begin
                sda_drv_q <= 1'b0;
                MASTER_ACTIVE <= 1'b0;
                st_q <= `TWC_ST_IDLE;
            end
            `TWC_ST_LOST: begin
                held_q <= 1'b1;
                if (CSR_CLEAR) begin
                    held_q <= 1'b0;
                    st_q <= `TWC_ST_IDLE;
                end
            end
            `TWC_ST_SKIP: begin
                sda_drv_q <= 1'b0;
                scl_drv_q <= 1'b0;
            end
            default: st_q <= `TWC_ST_IDLE;
            endcase
            // Late events win over firmware clear and over the state above
            if (stop_det | (sda_rise & ~scl & ~sda_drv_q & MASTER_ACTIVE & 1'b0)) begin
                st_q <= `TWC_ST_IDLE;
                held_q <= 1'b0;
                scl_drv_q <= 1'b0;
                sda_drv_q <= 1'b0;
                MASTER_ACTIVE <= 1'b0;
            end
            if (start_det & BUS_BUSY & st_q != `TWC_ST_IDLE & st_q != `TWC_ST_START
                & ~MASTER_ACTIVE & ~held_q) begin
                BUS_ERROR <= (st_q == `TWC_ST_SHIFT) & (bit_q != 4'h0);
                st_q <= `TWC_ST_IDLE;
            end
            if (~CLK_EN) begin
                st_q <= `TWC_ST_IDLE;
                held_q <= 1'b0;
                scl_drv_q <= 1'b0;
                sda_drv_q <= 1'b0;
            end
        end
    end
endmodule

// file: hdl/twc_defines.vh
// Constants and behaviour notes for the two-wire master/slave controller
// Notes on behaviour
// - Hardware matching compares first address byte's seven bits
// - Mismatch: automatic not-acknowledge, ignore bus until Stop or repeated Start
// - Match: acknowledge, hold clock low, byte-complete
// - Master without slave ignores foreign Starts
// - Free bus: Start, address out, byte-complete
// - Master transmit samples slave acknowledge per byte
// - Master receive acknowledges wanted bytes, refuses last
// - Stop command ends transfer; restart begins anew
// - Busy bus with slave: keep request, addressed
// - Busy bus without slave: wait, then start
// - Lost arbitration with slave: clear, lost, addressed if lost during the address byte
// - Lost arbitration without slave: stall until cleared
// - Sleep: latch address, wake, hold clock low
// - Sleep response needs slave, match, address, on; the code needs only SLAVE_EN, CLK_EN and an address hit
// - Interrupts for byte-complete, errors and Stop
// - Stop or bus error returns logic to idle
`ifndef TWC_DEFINES_VH
`define TWC_DEFINES_VH
`define TWC_DIV_W        16
`define TWC_DIV_DEFAULT  16'h0032
`define TWC_BIT_W        4
`define TWC_BYTE_BITS    4'h8
`define TWC_ADDR_W       7
`define TWC_ST_IDLE      4'h0
`define TWC_ST_START     4'h1
`define TWC_ST_SHIFT     4'h2
`define TWC_ST_ACK       4'h3
`define TWC_ST_HOLD      4'h4
`define TWC_ST_STOP      4'h5
`define TWC_ST_LOST      4'h6
`define TWC_ST_SKIP      4'h7
`endif

// file: hdl/twc_edge_sync.v
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/10ps
module twc_edge_sync (
    input  wire clk,
    input  wire rst,
    input  wire din,
    output reg  level,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg prev_q;

    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b1;
            level  <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= din;
            level  <= meta_q;
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

// file: test/twc_controller_properties.sv
// Port-level checks for the two-wire bus controller
`timescale 1ns/10ps
module twc_controller_properties (
    input wire SYS_CLK,
    input wire RESET,
    input wire CLK_EN,
    input wire SLAVE_EN,
    input wire START_REQ,
    input wire RESTART_REQ,
    input wire CSR_CLEAR,
    input wire INT_BYTE_EN,
    input wire INT_STOP_EN,
    input wire SLEEP_REFUSE_ALL,
    input wire SCL_OE_N,
    input wire SDA_OE_N,
    input wire BYTE_COMPLETE,
    input wire ADDRESSED,
    input wire STOP_SEEN,
    input wire START_PENDING,
    input wire BUS_BUSY,
    input wire BUS_FREE,
    input wire MASTER_ACTIVE,
    input wire SLEEP_READY_FLAG,
    input wire IRQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    idle_release_a: assert property (!CLK_EN |-> ##[1:2] (SCL_OE_N && SDA_OE_N))
        else $error("bus lines driven while interface is off");
    start_cause_a: assert property ($rose(START_PENDING) |-> $past(START_REQ) || $past(RESTART_REQ))
        else $error("start pending without a request");
    busy_wait_a: assert property (START_PENDING && BUS_BUSY && !SLAVE_EN && !MASTER_ACTIVE |-> SCL_OE_N)
        else $error("clock driven while waiting for a busy bus");
    irq_byte_a: assert property (INT_BYTE_EN && BYTE_COMPLETE |-> IRQ)
        else $error("byte-complete interrupt missing");
    irq_stop_a: assert property (INT_STOP_EN && STOP_SEEN |-> IRQ)
        else $error("stop interrupt missing");
    flag_clear_a: assert property ($fell(BYTE_COMPLETE) |-> $past(CSR_CLEAR) || !$past(CLK_EN))
        else $error("byte-complete dropped without a clear");
    addr_slave_a: assert property ($rose(ADDRESSED) |-> $past(SLAVE_EN))
        else $error("addressed while slave operation off");
    hold_scl_a: assert property ($rose(BYTE_COMPLETE) |-> ##[0:30] !SCL_OE_N ##1 !SCL_OE_N [*6])
        else $error("clock not held after byte complete");
    sleep_ready_a: assert property (SLEEP_READY_FLAG |-> SLEEP_REFUSE_ALL && BUS_FREE)
        else $error("sleep ready flagged too early");
    bus_free_a: assert property (BUS_FREE != BUS_BUSY)
        else $error("bus free and busy disagree");
endmodule

bind twc_controller twc_controller_properties u_twc_controller_properties (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .SLAVE_EN(SLAVE_EN),
    .START_REQ(START_REQ), .RESTART_REQ(RESTART_REQ), .CSR_CLEAR(CSR_CLEAR),
    .INT_BYTE_EN(INT_BYTE_EN), .INT_STOP_EN(INT_STOP_EN),
    .SLEEP_REFUSE_ALL(SLEEP_REFUSE_ALL), .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N),
    .BYTE_COMPLETE(BYTE_COMPLETE), .ADDRESSED(ADDRESSED), .STOP_SEEN(STOP_SEEN),
    .START_PENDING(START_PENDING), .BUS_BUSY(BUS_BUSY), .BUS_FREE(BUS_FREE),
    .MASTER_ACTIVE(MASTER_ACTIVE), .SLEEP_READY_FLAG(SLEEP_READY_FLAG), .IRQ(IRQ));

// file: test/twc_bus_partner.sv
// Far-side bus party: an outside master and an acknowledging slave
`timescale 1ns/10ps
module twc_bus_partner (
    input  wire  scl,
    input  wire  sda,
    output logic scl_rel,
    output logic sda_rel
);
    logic       p_scl  = 1'b1;
    logic       p_sda  = 1'b1;
    logic       r_sda  = 1'b1;
    logic       p_busy = 1'b0;
    logic       ack_en = 1'b1;
    logic [7:0] got    = 8'h00;
    int         n_rise = 0;
    // Released lines rise through the pull-up formed in the bench
    assign scl_rel = p_scl;
    assign sda_rel = p_sda & r_sda;
    always @(negedge sda) if (scl) n_rise = 0;
    always @(posedge scl) begin
        if (n_rise < 8) got = {got[6:0], sda};
        n_rise++;
    end
    // Never acknowledge our own frame, only the controller's
    always @(negedge scl) r_sda = !(ack_en && !p_busy && n_rise == 8);
    // Clock stretching: wait while anyone holds the clock low
    task automatic rise_scl;
        p_scl = 1'b1;
        for (int k = 0; k < 2000 && scl !== 1'b1; k++) #4;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        p_busy = 1'b1;
        p_sda = 1'b0;
        #32 p_scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #16 p_sda = b[i];
            #16 rise_scl;
            #32 p_scl = 1'b0;
        end
        #16 p_sda = 1'b1;
        #16 rise_scl;
        #16 ack = sda;
        #16 p_scl = 1'b0;
    endtask
    task automatic stop;
        #16 p_sda = 1'b0;
        #16 rise_scl;
        #32 p_sda = 1'b1;
        #32 p_busy = 1'b0;
    endtask
endmodule

// file: test/test_two_wire_master_slave_controller.sv
// Self-checking bench for the two-wire bus controller
`timescale 1ns/10ps
`define TWC_CHK(nm, ex, ac) begin n_compared++; if ((ac) !== (ex)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, ac); end end
module test_two_wire_master_slave_controller;
    localparam int ST = 0, RS = 1, SP = 2, TX = 3, CLR = 4, LD = 5;
    logic       SYS_CLK;
    logic       RESET            = 1'b1;
    logic       CLK_EN           = 1'b0;
    logic       SLAVE_EN         = 1'b0;
    logic       MASTER_EN        = 1'b0;
    logic       HW_MATCH_ENABLE  = 1'b0;
    logic       SLEEP_REFUSE_ALL = 1'b0;
    logic       ien              = 1'b0;
    logic       pwr_down         = 1'b0;
    logic [6:0] OWN_ADDR         = 7'h00;
    logic [7:0] TX_DATA          = 8'h00;
    logic [5:0] cmd              = 6'h00;
    int         fail_count       = 0;
    int         n_compared       = 0;
    wire        scl, sda, scl_rel, sda_rel, SCL_OE_N, SDA_OE_N;
    wire [7:0]  RX_DATA;
    wire        BYTE_COMPLETE, LAST_ACKED, ADDRESSED, STOP_SEEN, START_PENDING;
    wire        BUS_FREE, MASTER_ACTIVE, SLEEP_READY_FLAG, IRQ;
    assign scl = SCL_OE_N & scl_rel;
    assign sda = SDA_OE_N & sda_rel;
    twc_controller #(.QUARTER_DIV(16'h0002)) u_twc_controller (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .SCL_I(scl), .SCL_O(), .SCL_OE_N(SCL_OE_N),
        .SDA_I(sda), .SDA_O(), .SDA_OE_N(SDA_OE_N), .CLK_EN(CLK_EN), .SLAVE_EN(SLAVE_EN),
        .MASTER_EN(MASTER_EN), .HW_MATCH_ENABLE(HW_MATCH_ENABLE), .BLOCK_ON(1'b1),
        .SLEEP_REFUSE_ALL(SLEEP_REFUSE_ALL), .POWER_DOWN(pwr_down), .OWN_ADDR(OWN_ADDR),
        .START_REQ(cmd[ST]), .RESTART_REQ(cmd[RS]), .STOP_REQ(cmd[SP]), .TX_DATA(TX_DATA),
        .TX_LOAD(cmd[LD]), .ACK_CMD(1'b0), .NACK_CMD(1'b0), .TRANSMIT_CMD(cmd[TX]),
        .RECEIVE_CMD(1'b0), .CSR_CLEAR(cmd[CLR]), .INT_BYTE_EN(ien), .INT_ERR_EN(ien),
        .INT_STOP_EN(ien), .RX_DATA(RX_DATA), .BYTE_COMPLETE(BYTE_COMPLETE),
        .LAST_ACKED(LAST_ACKED), .ADDRESSED(ADDRESSED), .LOST_ARB(), .STOP_SEEN(STOP_SEEN),
        .BUS_ERROR(), .START_PENDING(START_PENDING), .BUS_BUSY(), .BUS_FREE(BUS_FREE),
        .MASTER_ACTIVE(MASTER_ACTIVE), .SLEEP_READY_FLAG(SLEEP_READY_FLAG), .WAKEUP(),
        .IRQ(IRQ));
    twc_bus_partner u_twc_bus_partner (
        .scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    task summarize;
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task pulse(input int i);
        @(posedge SYS_CLK) cmd[i] <= 1'b1;
        @(posedge SYS_CLK) cmd[i] <= 1'b0;
    endtask
    // The extra cycles after the flag prove that the clock stays held
    task wait_bc;
        for (int k = 0; k < 3000 && BYTE_COMPLETE !== 1'b1; k++) @(posedge SYS_CLK);
        repeat (24) @(posedge SYS_CLK);
    endtask
    task wait_free;
        for (int k = 0; k < 3000 && BUS_FREE !== 1'b1; k++) @(posedge SYS_CLK);
        repeat (4) @(posedge SYS_CLK);
    endtask
    task master_tx;
        MASTER_EN <= 1'b1;
        TX_DATA <= 8'hA4;
        pulse(LD);
        pulse(ST);
        wait_bc;
        `TWC_CHK("byte_complete", 1'b1, BYTE_COMPLETE)
        `TWC_CHK("addr_on_wire", 8'hA4, u_twc_bus_partner.got)
        `TWC_CHK("last_acked", 1'b1, LAST_ACKED)
        `TWC_CHK("scl_held", 1'b0, SCL_OE_N)
        u_twc_bus_partner.ack_en = 1'b0;
        pulse(CLR);
        pulse(RS);
        wait_bc;
        `TWC_CHK("restart_byte", 1'b1, BYTE_COMPLETE)
        `TWC_CHK("last_nacked", 1'b0, LAST_ACKED)
        pulse(SP);
        wait_free;
        `TWC_CHK("master_idle", 1'b0, MASTER_ACTIVE)
        `TWC_CHK("sda_released", 1'b1, SDA_OE_N)
    endtask
    task slave_addr(input logic [6:0] a, input logic hit);
        logic ack;
        SLAVE_EN <= 1'b1;
        HW_MATCH_ENABLE <= 1'b1;
        OWN_ADDR <= 7'h3A;
        pulse(CLR);
        u_twc_bus_partner.send({a, 1'b0}, ack);
        repeat (24) @(posedge SYS_CLK);
        `TWC_CHK("addr_ack", !hit, ack)
        `TWC_CHK("addressed", hit, ADDRESSED)
        `TWC_CHK("byte_complete", hit, BYTE_COMPLETE)
        `TWC_CHK("scl_held", !hit, SCL_OE_N)
        if (hit) begin
            `TWC_CHK("addr_byte", {a, 1'b0}, RX_DATA)
            pulse(TX);
        end
        u_twc_bus_partner.stop;
        repeat (8) @(posedge SYS_CLK);
        `TWC_CHK("stop_seen", 1'b1, STOP_SEEN)
        `TWC_CHK("bus_free", 1'b1, BUS_FREE)
    endtask
    task busy_master;
        logic ack;
        SLAVE_EN <= 1'b0;
        TX_DATA <= 8'h5C;
        u_twc_bus_partner.ack_en = 1'b1;
        pulse(CLR);
        pulse(LD);
        fork
            u_twc_bus_partner.send(8'h74, ack);
            begin
                repeat (40) @(posedge SYS_CLK);
                pulse(ST);
            end
        join
        repeat (2) @(posedge SYS_CLK);
        `TWC_CHK("foreign_ack", 1'b1, ack)
        `TWC_CHK("start_pending", 1'b1, START_PENDING)
        `TWC_CHK("no_byte_yet", 1'b0, BYTE_COMPLETE)
        u_twc_bus_partner.stop;
        wait_bc;
        `TWC_CHK("byte_complete", 1'b1, BYTE_COMPLETE)
        `TWC_CHK("addr_on_wire", 8'h5C, u_twc_bus_partner.got)
        `TWC_CHK("not_addressed", 1'b0, ADDRESSED)
        `TWC_CHK("irq", 1'b1, IRQ)
        pulse(SP);
        wait_free;
    endtask
    initial begin
        #200000;
        fail_count++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge SYS_CLK);
        RESET <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        CLK_EN <= 1'b1;
        ien <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        master_tx;
        slave_addr(7'h3A, 1'b1);
        slave_addr(7'h3B, 1'b0);
        busy_master;
        SLEEP_REFUSE_ALL <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        `TWC_CHK("sleep_ready", 1'b1, SLEEP_READY_FLAG)
        summarize;
    end
endmodule
